/* File: hdl/mpc_pkg.sv */
// package for the meter pulse input counter: sizes, timing, register map
// assumes a 10 MHz system clock and one shared asynchronous reset
// Function
// - sample all twelve inputs every 1 ms
// - per input debounce 0..20 s, own edge
// - edge setting 1 counts low-to-high
// - edge setting 0 counts high-to-low
// - level changes after stable for debounce time
// - status shows debounced level, not raw
// - per channel gate accepts or drops pulses
// - stopped channel keeps its level status
// - visibility flag changes nothing but listing
// - temp counter handed to energy every 1.5 s
// - instantaneous power from inter-pulse interval
// - power is energy times factor over time
package mpc_pkg;
	localparam int NCH = 12;
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
	localparam int HO_MS = 1500;
	localparam int DEB_W = 15;
	localparam int CNT_W = 16;
	localparam logic [DEB_W-1:0] DEB_MAX_MS = 15'h4E20;
	localparam logic [15:0] PFACTOR_RST = 16'h0E10;
	localparam logic [9:0] MS_PER_S = 10'h3E8;
	// register offsets, one address per 32-bit register on the plain port
	localparam logic [7:0] A_GATE = 8'h00;
	localparam logic [7:0] A_VIS = 8'h01;
	localparam logic [7:0] A_EDGE = 8'h02;
	localparam logic [7:0] A_LEVEL = 8'h03;
	localparam logic [7:0] A_PFAC = 8'h04;
	localparam logic [7:0] A_PCMD = 8'h05;
	localparam logic [7:0] A_PRES = 8'h06;
	localparam logic [7:0] A_ESEL = 8'h07;
	localparam logic [7:0] A_EVAL = 8'h08;
	localparam logic [7:0] A_DEB = 8'h10;
	localparam logic [7:0] A_WGT = 8'h20;
	localparam logic [7:0] A_IVL = 8'h40;
	localparam logic [7:0] A_TMP = 8'h50;
	localparam logic [7:0] A_LCNT = 8'h60;
	// power command fields
	localparam int PCMD_KIND = 4;
	localparam int PCMD_BUSY = 31;
	typedef enum logic [2:0] {
		HO_IDLE = 3'b001,
		HO_RD = 3'b010,
		HO_WR = 3'b100
	} mpc_ho_t;
	typedef enum logic [1:0] {
		DV_IDLE = 2'b01,
		DV_RUN = 2'b10
	} mpc_dv_t;
	// true when addr lies in a per-channel group and names a real channel
	function automatic logic ch_hit(input logic [7:0] addr, input logic [7:0] base);
		ch_hit = (addr[7:4] == base[7:4]) && (addr[3:0] < 4'(NCH));
	endfunction
endpackage

/* File: hdl/mpc_mem.sv */
// energy total store: one read/write port and one read-only port
// assumes the owner never writes one word from two places at once
`timescale 1ns/1ps
module mpc_mem
	import mpc_pkg::*;
(
	// clock and reset
	input logic mclk_in,
	input logic rstn_in,
	// port a, read and write
	input logic [3:0] a_addr_in,
	input logic a_we_in,
	input logic [31:0] a_wdata_in,
	output logic [31:0] a_rdata_out,
	// port b, read only
	input logic [3:0] b_addr_in,
	output logic [31:0] b_rdata_out
);
	typedef struct packed {
		logic [NCH-1:0][31:0] mem; // the stored totals
		logic [31:0] a_rd; // registered read, port a
		logic [31:0] b_rd; // registered read, port b
	} mpc_mem_st_t;
	mpc_mem_st_t q, d;

	// reads take one cycle; an out-of-range address reads zero
	always_comb begin
		d = q;
		d.a_rd = (a_addr_in < 4'(NCH)) ? q.mem[a_addr_in] : 32'h0000_0000;
		d.b_rd = (b_addr_in < 4'(NCH)) ? q.mem[b_addr_in] : 32'h0000_0000;
		if (a_we_in && (a_addr_in < 4'(NCH))) begin
			d.mem[a_addr_in] = a_wdata_in;
		end
	end

	// totals clear on reset
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign a_rdata_out = q.a_rd;
	assign b_rdata_out = q.b_rd;
endmodule

/* File: hdl/mpc_div.sv */
// serial divider for power figures: 64-bit dividend, 32-bit divisor
// assumes start only while not busy; a zero divisor yields zero
`timescale 1ns/1ps
module mpc_div
	import mpc_pkg::*;
(
	// clock and reset
	input logic mclk_in,
	input logic rstn_in,
	// request
	input logic start_in,
	input logic [63:0] num_in,
	input logic [31:0] den_in,
	// answer
	output logic busy_out,
	output logic done_out,
	output logic [31:0] quo_out
);
	typedef struct packed {
		mpc_dv_t st; // idle or running
		logic [6:0] cnt; // bits still to go
		logic [32:0] rem; // partial remainder
		logic [63:0] quo; // dividend shifting into quotient
		logic [31:0] den; // held divisor
		logic done; // one-cycle finish pulse
		logic [31:0] res; // saturated result
	} mpc_div_st_t;
	mpc_div_st_t q, d;
	logic [32:0] rs;

	// one quotient bit per cycle: slow but tiny, and power is never urgent
	always_comb begin
		d = q;
		rs = 33'h0_0000_0000;
		d.done = 1'b0;
		case (q.st)
			DV_IDLE: begin
				if (start_in) begin
					if (den_in == 32'h0000_0000) begin
						d.res = 32'h0000_0000; // no interval yet: report no power
						d.done = 1'b1;
					end else begin
						d.st = DV_RUN;
						d.cnt = 7'h40;
						d.rem = 33'h0_0000_0000;
						d.quo = num_in;
						d.den = den_in;
					end
				end
			end
			DV_RUN: begin
				rs = {q.rem[31:0], q.quo[63]};
				d.quo = {q.quo[62:0], 1'b0};
				if (rs >= {1'b0, q.den}) begin
					d.rem = rs - {1'b0, q.den};
					d.quo[0] = 1'b1;
				end else begin
					d.rem = rs;
				end
				d.cnt = q.cnt - 7'h01;
				if (q.cnt == 7'h01) begin
					d.st = DV_IDLE;
					d.done = 1'b1;
					// clip rather than wrap when the figure overflows
					d.res = (d.quo[63:32] != 32'h0000_0000) ? 32'hFFFF_FFFF : d.quo[31:0];
				end
			end
			default: d.st = DV_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '{st: DV_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign busy_out = (q.st == DV_RUN);
	assign done_out = q.done;
	assign quo_out = q.res;
endmodule

/* File: hdl/mpc_top.sv */
// meter pulse input counter: sampling, debounce, edge count, gating,
// handover into energy totals, interval timing and power on request
// assumes potential-free meter contacts on pulse_in, asynchronous to mclk_in
`timescale 1ns/1ps
module mpc_top
	import mpc_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF // cycles per 1 ms tick
) (
	// clock and reset
	input logic mclk_in,
	input logic rstn_in,
	// meter inputs
	input logic [NCH-1:0] pulse_in,
	// register port
	input logic [7:0] addr_in,
	input logic [31:0] wdata_in,
	input logic wr_in,
	input logic rd_in,
	output logic [31:0] rdata_out,
	// status
	output logic [NCH-1:0] level_out,
	output logic [NCH-1:0] visible_out
);
	typedef struct packed {
		logic [NCH-1:0] s1; // synchroniser stage one
		logic [NCH-1:0] s2; // stage two
		logic [NCH-1:0] s3; // stage three
		logic [NCH-1:0] smp; // agreed input level
		logic [NCH-1:0] lvl; // debounced level
		logic [NCH-1:0][DEB_W-1:0] deb_cnt; // ms the new level has held
		logic [NCH-1:0][DEB_W-1:0] deb_t; // debounce time in ms
		logic [NCH-1:0] edge_pos; // 1 rising, 0 falling
		logic [NCH-1:0] gate; // acceptance gate per channel
		logic [NCH-1:0] vis; // display visibility per channel
		logic [13:0] tick_cnt; // divider for the 1 ms tick
		logic tick; // one-cycle 1 ms enable
		logic [10:0] ho_cnt; // ms since the last handover
		logic [NCH-1:0][CNT_W-1:0] tmp; // temporary pulse counters
		logic [NCH-1:0][CNT_W-1:0] lcnt; // counts of the last handover
		logic [NCH-1:0][CNT_W-1:0] ivt; // running inter-pulse timer
		logic [NCH-1:0][CNT_W-1:0] ivl; // last measured interval
		logic [NCH-1:0][15:0] wgt; // energy per pulse
		logic [15:0] pfac; // power scale factor
		mpc_ho_t ho_st; // handover walker state
		logic [3:0] ho_ch; // channel being handed over
		logic [3:0] esel; // channel shown in the energy view
		logic pkind; // 0 instantaneous, 1 interval power
		logic [3:0] pch; // channel of the power request
		logic dv_go; // start pulse to divider
		logic [63:0] dv_num; // dividend for divider
		logic [31:0] dv_den; // divisor for divider
		logic [31:0] pres; // last power result
		logic [31:0] rdata; // read data register
	} mpc_st_t;
	mpc_st_t q, d;

	logic ho_fire; // handover starts this cycle
	logic acc; // pulse accepted on current channel
	logic [31:0] mem_a_rd;
	logic [31:0] mem_b_rd;
	logic [31:0] mem_a_wd;
	logic dv_busy;
	logic dv_done;
	logic [31:0] dv_quo;

	// handover adds pulses times weight onto the stored total
	// both factors widened first so the 16x16 product keeps all its bits
	assign mem_a_wd = mem_a_rd + (32'(q.lcnt[q.ho_ch]) * 32'(q.wgt[q.ho_ch]));

	mpc_mem u_mem (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.a_addr_in(q.ho_ch),
		.a_we_in(q.ho_st == HO_WR),
		.a_wdata_in(mem_a_wd),
		.a_rdata_out(mem_a_rd),
		.b_addr_in(q.esel),
		.b_rdata_out(mem_b_rd)
	);

	mpc_div u_div (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.start_in(q.dv_go),
		.num_in(q.dv_num),
		.den_in(q.dv_den),
		.busy_out(dv_busy),
		.done_out(dv_done),
		.quo_out(dv_quo)
	);

	// next state of the whole block
	always_comb begin
		d = q;
		ho_fire = 1'b0;
		acc = 1'b0;
		// three-stage synchroniser; a change counts once stages two and three agree
		d.s1 = pulse_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.smp = (q.s2 & q.s3) | (q.smp & (q.s2 ^ q.s3));
		// one common 1 ms tick for every input
		d.tick = 1'b0;
		if (q.tick_cnt == 14'(TICK_CYC - 1)) begin
			d.tick_cnt = 14'h0000;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 14'h0001;
		end
		// handover period in ms ticks, inside the one to two second window
		if (q.tick) begin
			if (q.ho_cnt == 11'(HO_MS - 1)) begin
				d.ho_cnt = 11'h000;
				ho_fire = 1'b1;
			end else begin
				d.ho_cnt = q.ho_cnt + 11'h001;
			end
		end
		// per-channel filter, edge, gate and counters
		for (int i = 0; i < NCH; i++) begin
			if (q.tick) begin
				if (q.smp[i] == q.lvl[i]) begin
					d.deb_cnt[i] = '0; // bounce back restarts the hold
				end else if (16'(q.deb_cnt[i]) + 16'h0001 >= 16'(q.deb_t[i])) begin
					d.lvl[i] = q.smp[i];
					d.deb_cnt[i] = '0;
				end else begin
					d.deb_cnt[i] = q.deb_cnt[i] + 15'h0001;
				end
				// interval timer in ms, held at full scale when idle
				if (q.ivt[i] != 16'hFFFF) begin
					d.ivt[i] = q.ivt[i] + 16'h0001;
				end
			end
			// edges come from the debounced level only
			acc = q.gate[i] & (q.edge_pos[i] ? (d.lvl[i] & ~q.lvl[i])
				: (~d.lvl[i] & q.lvl[i]));
			if (acc) begin
				d.ivl[i] = d.ivt[i];
				d.ivt[i] = 16'h0000;
			end
			// snapshot and restart in the same cycle so no pulse is lost
			if (ho_fire) begin
				d.lcnt[i] = q.tmp[i];
				d.tmp[i] = acc ? 16'h0001 : 16'h0000;
			end else if (acc && (q.tmp[i] != 16'hFFFF)) begin
				d.tmp[i] = q.tmp[i] + 16'h0001;
			end
		end
		// handover walker: read a total, write it back increased
		case (q.ho_st)
			HO_IDLE: begin
				if (ho_fire) begin
					d.ho_st = HO_RD;
					d.ho_ch = 4'h0;
				end
			end
			HO_RD: d.ho_st = HO_WR; // memory read takes this cycle
			HO_WR: begin
				if (q.ho_ch == 4'(NCH - 1)) begin
					d.ho_st = HO_IDLE;
				end else begin
					d.ho_ch = q.ho_ch + 4'h1;
					d.ho_st = HO_RD;
				end
			end
			default: d.ho_st = HO_IDLE;
		endcase
		// divider start is a single pulse
		d.dv_go = 1'b0;
		if (dv_done) begin
			d.pres = dv_quo;
		end
		// register writes
		if (wr_in) begin
			if (addr_in == A_GATE) begin
				d.gate = wdata_in[NCH-1:0];
			end else if (addr_in == A_VIS) begin
				d.vis = wdata_in[NCH-1:0];
			end else if (addr_in == A_EDGE) begin
				d.edge_pos = wdata_in[NCH-1:0];
			end else if (addr_in == A_PFAC) begin
				d.pfac = wdata_in[15:0];
			end else if (addr_in == A_ESEL) begin
				d.esel = wdata_in[3:0];
			end else if (addr_in == A_PCMD) begin
				// a request while busy or for a missing channel is dropped
				if (!dv_busy && !q.dv_go && (wdata_in[3:0] < 4'(NCH))) begin
					d.pkind = wdata_in[PCMD_KIND];
					d.pch = wdata_in[3:0];
					d.dv_go = 1'b1;
					if (wdata_in[PCMD_KIND]) begin
						// mean power over the last handover window
						d.dv_num = 64'(q.lcnt[wdata_in[3:0]]) * 64'(q.wgt[wdata_in[3:0]])
							* 64'(q.pfac) * 64'(MS_PER_S);
						d.dv_den = 32'(HO_MS);
					end else begin
						// one pulse worth of energy over the last interval
						d.dv_num = 64'(q.wgt[wdata_in[3:0]]) * 64'(q.pfac)
							* 64'(MS_PER_S);
						d.dv_den = 32'(q.ivl[wdata_in[3:0]]);
					end
				end
			end else if (ch_hit(addr_in, A_DEB)) begin
				// anything past twenty seconds is held at the limit
				d.deb_t[addr_in[3:0]] = (wdata_in[31:DEB_W] != '0
					|| wdata_in[DEB_W-1:0] > DEB_MAX_MS)
					? DEB_MAX_MS : wdata_in[DEB_W-1:0];
			end else if (ch_hit(addr_in, A_WGT)) begin
				d.wgt[addr_in[3:0]] = wdata_in[15:0];
			end
		end
		// register reads, answered in the following cycle
		if (rd_in) begin
			if (addr_in == A_GATE) begin
				d.rdata = 32'(q.gate);
			end else if (addr_in == A_VIS) begin
				d.rdata = 32'(q.vis);
			end else if (addr_in == A_EDGE) begin
				d.rdata = 32'(q.edge_pos);
			end else if (addr_in == A_LEVEL) begin
				d.rdata = 32'(q.lvl);
			end else if (addr_in == A_PFAC) begin
				d.rdata = 32'(q.pfac);
			end else if (addr_in == A_PCMD) begin
				d.rdata = 32'h0000_0000;
				d.rdata[PCMD_BUSY] = dv_busy | q.dv_go;
				d.rdata[PCMD_KIND] = q.pkind;
				d.rdata[3:0] = q.pch;
			end else if (addr_in == A_PRES) begin
				d.rdata = q.pres;
			end else if (addr_in == A_ESEL) begin
				d.rdata = 32'(q.esel);
			end else if (addr_in == A_EVAL) begin
				d.rdata = mem_b_rd; // total of the selected channel
			end else if (ch_hit(addr_in, A_DEB)) begin
				d.rdata = 32'(q.deb_t[addr_in[3:0]]);
			end else if (ch_hit(addr_in, A_WGT)) begin
				d.rdata = 32'(q.wgt[addr_in[3:0]]);
			end else if (ch_hit(addr_in, A_IVL)) begin
				d.rdata = 32'(q.ivl[addr_in[3:0]]);
			end else if (ch_hit(addr_in, A_TMP)) begin
				d.rdata = 32'(q.tmp[addr_in[3:0]]);
			end else if (ch_hit(addr_in, A_LCNT)) begin
				d.rdata = 32'(q.lcnt[addr_in[3:0]]);
			end else begin
				d.rdata = 32'h0000_0000; // unmapped reads zero
			end
		end
	end

	// single state register; gates open, rising edges, factor at default
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '{ho_st: HO_IDLE, pfac: PFACTOR_RST, gate: '1, vis: '1, edge_pos: '1,
				default: '0};
		end else begin
			q <= d;
		end
	end

	// all outputs straight from state flops
	assign rdata_out = q.rdata;
	assign level_out = q.lvl;
	assign visible_out = q.vis;
endmodule

/* File: dv/mpc_top_props.sv */
// checker for the meter pulse input counter top: register port and status
// assumes a bind onto mpc_top and sees only its ports
`timescale 1ns/1ps
module mpc_top_props
	import mpc_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF // cycles per 1 ms tick
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// watched ports
	input wire logic [NCH-1:0] pulse_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic [NCH-1:0] level_out,
	input wire logic [NCH-1:0] visible_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	logic [NCH-1:0] pulse_q; // contacts one cycle ago
	logic [3:0] quiet_q; // cycles the contacts held still, saturating
	// quiet count lets the level check wait out the synchroniser
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pulse_q <= '0;
			quiet_q <= 4'h0;
		end else begin
			pulse_q <= pulse_in;
			quiet_q <= (pulse_in != pulse_q) ? 4'h0 : ((quiet_q == 4'hF) ? 4'hF : quiet_q + 4'h1);
		end
	end
	sequence s_cfg_wr;
		wr_in && (addr_in == A_GATE || addr_in == A_VIS || addr_in == A_EDGE);
	endsequence
	sequence s_deb_big;
		wr_in && addr_in[7:4] == 4'h1 && addr_in[3:0] < 4'hC && wdata_in > 32'h00004E20;
	endsequence
	sequence s_same_rd;
		rd_in && addr_in == $past(addr_in);
	endsequence
	property p_cfg_readback;
		s_cfg_wr ##1 s_same_rd |=> rdata_out == {20'h0, $past(wdata_in[11:0], 2)};
	endproperty
	a_cfg_readback: assert property (p_cfg_readback) else $error("config readback wrong");
	property p_deb_clamp;
		s_deb_big ##1 s_same_rd |=> rdata_out == 32'h00004E20;
	endproperty
	a_deb_clamp: assert property (p_deb_clamp) else $error("debounce not clamped");
	property p_vis_out;
		wr_in && addr_in == A_VIS |=> ##1 visible_out == $past(wdata_in[11:0], 2);
	endproperty
	a_vis_out: assert property (p_vis_out) else $error("visibility not applied");
	property p_level_rd;
		rd_in && addr_in == A_LEVEL |=> rdata_out == {20'h0, $past(level_out)};
	endproperty
	a_level_rd: assert property (p_level_rd) else $error("level read wrong");
	property p_rd_hold;
		!rd_in |=> $stable(rdata_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_tick_gap;
		$changed(level_out) |=> $stable(level_out)[*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("level moved between ticks");
	property p_quiet;
		quiet_q >= 4'h8 && pulse_in == level_out |=> $stable(level_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("level left a steady input");
	property p_rst_vals;
		$rose(rstn_in) |-> visible_out == 12'hFFF && level_out == 12'h0 && rdata_out == 32'h0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule

/* File: dv/mpc_meter_model.sv */
// meter model: twelve potential-free contacts moved on command
// assumes one command at a time; contacts open (low) after reset
`timescale 1ns/1ps
module mpc_meter_model
	import mpc_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// command from the bench
	input wire logic stb_in,
	input wire logic [3:0] ch_in,
	input wire logic lvl_in,
	input wire logic bounce_in,
	// contacts
	output logic [NCH-1:0] pulse_out
);
	logic [2:0] chat_q; // bounce steps left
	logic [3:0] ch_q; // contact being moved
	logic tgt_q; // level it settles at
	// a bouncing contact chatters for less than one tick before settling
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pulse_out <= '0;
			chat_q <= 3'h0;
			ch_q <= 4'h0;
			tgt_q <= 1'b0;
		end else if (stb_in) begin
			pulse_out[ch_in] <= lvl_in;
			ch_q <= ch_in;
			tgt_q <= lvl_in;
			chat_q <= bounce_in ? 3'h5 : 3'h0;
		end else if (chat_q != 3'h0) begin
			pulse_out[ch_q] <= (chat_q == 3'h1) ? tgt_q : ~pulse_out[ch_q];
			chat_q <= chat_q - 3'h1;
		end
	end
endmodule

/* File: dv/mpc_tb_top.sv */
// self-checking bench for the meter pulse input counter
// assumes the meter model on the contacts and a 20-cycle tick
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
module mpc_tb_top;
	import mpc_pkg::*;
	localparam int TK = 20; // short tick keeps the run small
	typedef struct {int ch; logic esel; logic gate; logic vis; logic [15:0] deb; logic bnc; logic [31:0] cnt;} mpc_row_t;
	mpc_row_t rows[4] = '{'{0, 1'b1, 1'b1, 1'b1, 16'h0, 1'b0, 32'h3},
		'{1, 1'b0, 1'b1, 1'b1, 16'h2, 1'b1, 32'h3}, '{2, 1'b1, 1'b0, 1'b1, 16'h1, 1'b0, 32'h0},
		'{3, 1'b1, 1'b1, 1'b0, 16'h1, 1'b0, 32'h3}};
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] addr_in = 8'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic [NCH-1:0] level_out, visible_out, pulse;
	logic m_stb = 1'b0;
	logic [3:0] m_ch = 4'h0;
	logic m_lvl = 1'b0;
	logic m_bnc = 1'b0;
	logic [11:0] gate_v = 12'hFFF, edge_v = 12'hFFF, vis_v = 12'hFFF;
	logic [31:0] q;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	mpc_top #(.TICK_CYC(TK)) mpc_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .pulse_in(pulse),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .level_out(level_out), .visible_out(visible_out));
	mpc_meter_model mpc_meter_model_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .stb_in(m_stb),
		.ch_in(m_ch), .lvl_in(m_lvl), .bounce_in(m_bnc), .pulse_out(pulse));
	always #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= cyc + 1;
	// write then read back at once, no gap between strobes
	task automatic wrrd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 r = rdata_out;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge mclk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 r = rdata_out;
	endtask
	task automatic setc(input int ch, input logic lvl, input logic bnc);
		@(posedge mclk_in);
		m_stb <= 1'b1;
		m_ch <= 4'(ch);
		m_lvl <= lvl;
		m_bnc <= bnc;
		@(posedge mclk_in);
		m_stb <= 1'b0;
	endtask
	// one full pulse; period is a whole number of ticks
	task automatic pulse_once(input int ch, input int deb, input logic bnc);
		setc(ch, 1'b1, bnc);
		repeat ((deb + 2) * TK - 2) @(posedge mclk_in);
		#1 `CHK(level_out[ch], 1'b1, "level not high")
		setc(ch, 1'b0, bnc);
		repeat ((deb + 2) * TK - 2) @(posedge mclk_in);
	endtask
	task automatic busy_wait;
		logic [31:0] s;
		int k;
		k = 0;
		do begin
			rd(A_PCMD, s);
			k++;
		end while (s[PCMD_BUSY] !== 1'b0 && k < 60);
		if (k >= 60) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk_in);
		rstn_in <= 1'b1;
		rd(A_PFAC, q);
		`CHK(q, {16'h0, PFACTOR_RST}, "power factor reset")
		rd(8'h0F, q);
		`CHK(q, 32'h0, "unmapped read")
		foreach (rows[i]) begin
			gate_v[rows[i].ch] = rows[i].gate;
			edge_v[rows[i].ch] = rows[i].esel;
			vis_v[rows[i].ch] = rows[i].vis;
			wrrd(A_GATE, {20'h0, gate_v}, q);
			`CHK(q[11:0], gate_v, "gate readback")
			wrrd(A_EDGE, {20'h0, edge_v}, q);
			`CHK(q[11:0], edge_v, "edge readback")
			wrrd(A_VIS, {20'h0, vis_v}, q);
			`CHK(visible_out, vis_v, "visibility flags")
			wrrd(A_DEB + 8'(rows[i].ch), {16'h0, rows[i].deb}, q);
			`CHK(q[15:0], rows[i].deb, "debounce readback")
			repeat (3) pulse_once(rows[i].ch, int'(rows[i].deb), rows[i].bnc);
			rd(A_TMP + 8'(rows[i].ch), q);
			`CHK(q, rows[i].cnt, "temp count")
		end
		rd(A_IVL, q);
		`CHK(q, 32'h4, "pulse interval")
		wrrd(A_DEB + 8'h5, 32'h00005000, q);
		`CHK(q, 32'h00004E20, "debounce clamp")
		wr(A_DEB + 8'h4, 32'h5);
		setc(4, 1'b1, 1'b0);
		repeat (3 * TK) @(posedge mclk_in);
		setc(4, 1'b0, 1'b0);
		repeat (8 * TK) @(posedge mclk_in);
		rd(A_LEVEL, q);
		`CHK(q, 32'h0, "short pulse reached level")
		pulse_once(4, 5, 1'b0);
		rd(A_TMP + 8'h4, q);
		`CHK(q, 32'h1, "long pulse count")
		wr(A_WGT, 32'h2);
		wr(A_PCMD, 32'h0);
		busy_wait();
		rd(A_PRES, q);
		`CHK(q, 32'h001B7740, "instantaneous power")
		while (cyc < 1500 * TK + 100) @(posedge mclk_in);
		rd(A_LCNT, q);
		`CHK(q, 32'h3, "handover count")
		rd(A_TMP, q);
		`CHK(q, 32'h0, "temp cleared")
		wr(A_ESEL, 32'h0);
		rd(A_EVAL, q);
		`CHK(q, 32'h6, "energy total")
		wr(A_PCMD, 32'h10);
		busy_wait();
		rd(A_PRES, q);
		`CHK(q, 32'h00003840, "interval power")
		wrrd(A_PFAC, 32'h0000003C, q);
		`CHK(q, 32'h0000003C, "power factor readback")
		wr(A_PCMD, 32'h10);
		busy_wait();
		rd(A_PRES, q);
		`CHK(q, 32'h000000F0, "interval power per minute")
		@(posedge mclk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		#1 `CHK(visible_out, 12'hFFF, "visibility after reset")
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge mclk_in);
		n_mismatch++;
		complete_run();
	end
endmodule
bind mpc_top mpc_top_props #(.TICK_CYC(TICK_CYC)) mpc_top_props_i (.mclk_in(mclk_in),
	.rstn_in(rstn_in), .pulse_in(pulse_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .level_out(level_out),
	.visible_out(visible_out));
